/* src/rx_back_end.sv */
// Device end: decimator, Hilbert combiner, format and output multiplexer.
// Assumes ADC samples arrive on the core clock with a sample strobe, and
// configuration bits are static for several sample pairs.
`timescale 1ns/1ps
module rx_back_end
    import rx_pkg::*;
(
    input  wire logic         MCLK_I,
    input  wire logic         ARST_N_I,
    input  wire rx_pkg::word_t ADC_A_I,
    input  wire rx_pkg::word_t ADC_B_I,
    input  wire logic         ADC_STB_I,
    input  wire logic         DECIM_EN_I,
    input  wire logic         HILBERT_EN_I,
    input  wire logic         TWOS_COMP_I,
    input  wire logic         INTERLEAVE_I,
    input  wire logic         SAMPLE_RATE_HALVE_I,
    input  wire logic         CLK_SEL_I,
    input  wire logic         REG_WR_I,
    input  wire logic [7:0]   REG_ADDR_I,
    input  wire logic [7:0]   REG_WDATA_I,
    output logic [7:0]        REG_RDATA_O,
    output logic [1:0]        PATH_PWRDN_O,
    output logic              SHARED_REF_O,
    output logic              SAMPLE_TAKE_O,
    rx_link_if.dev            link
);
    import rx_pkg::*;
    typedef enum logic [1:0] {OUT_IDLE, OUT_B} out_e;
    word_t                  dla_r [HB_TAPS];
    word_t                  dlb_r [HB_TAPS];
    word_t                  dla_nxt [HB_TAPS];
    word_t                  dlb_nxt [HB_TAPS];
    word_t                  hil_r [HIL_TAPS];
    word_t                  hil_nxt [HIL_TAPS];
    logic                   ph_r, ph_nxt, div_r, div_nxt;
    logic                   dec_r, hil_r_en, fmt_r, il_r, cfg_dec, cfg_hil, cfg_fmt, cfg_il;
    logic [1:0]             pwr_r, pwr_nxt;
    logic                   shref_r, shref_nxt;
    logic                   take;
    logic                   stage_vld;
    word_t                  stage_a, stage_b, hil_out, comb_a;
    pair_s                  fin, fout;
    logic                   fin_vld, fin_rdy, fout_vld, fout_rdy;
    out_e                   st_r, st_nxt;
    word_t                  bus_a_r, bus_a_nxt, bus_b_r, bus_b_nxt;
    logic                   tag_r, tag_nxt, wv_r, wv_nxt, clk_r, clk_nxt;

    function automatic word_t fir_hb(input word_t d [HB_TAPS]);
        logic signed [ACC_W-1:0] acc;
        acc = '0;
        for (int i = 0; i < HB_TAPS; i++) begin
            acc = acc + ACC_W'($signed(d[i]) * HB_COEF[i]);
        end
        return sat_shift(acc);
    endfunction : fir_hb

    function automatic word_t fmt(input word_t w, input logic twos);
        return twos ? w : {~w[DW-1], w[DW-2:0]};
    endfunction : fmt

    // Rate halving skips every second strobe.
    assign take = ADC_STB_I && (!SAMPLE_RATE_HALVE_I || div_r);
    assign SAMPLE_TAKE_O = take;

    always_comb begin
        div_nxt = ADC_STB_I ? ~div_r : div_r;
        ph_nxt  = ph_r;
        dla_nxt = dla_r;
        dlb_nxt = dlb_r;
        if (take) begin
            dla_nxt[0] = ADC_A_I;
            dlb_nxt[0] = ADC_B_I;
            for (int i = 1; i < HB_TAPS; i++) begin
                dla_nxt[i] = dla_r[i-1];
                dlb_nxt[i] = dlb_r[i-1];
            end
            ph_nxt = ~ph_r;
        end
    end

    // Decimated output fires on one phase only; bypass fires on every sample.
    always_comb begin
        stage_vld = take && (!dec_r || ph_r);
        stage_a   = dec_r ? fir_hb(dla_nxt) : ADC_A_I;
        stage_b   = dec_r ? fir_hb(dlb_nxt) : ADC_B_I;
    end

    // Antisymmetric FIR gives the quadrature shift; A is used undelayed, not aligned to its centre tap.
    always_comb begin
        logic signed [ACC_W-1:0] acc;
        acc = '0;
        hil_nxt = hil_r;
        if (stage_vld) begin
            hil_nxt[0] = stage_b;
            for (int i = 1; i < HIL_TAPS; i++) begin
                hil_nxt[i] = hil_r[i-1];
            end
        end
        for (int i = 0; i < HIL_TAPS; i++) begin
            acc = acc + ACC_W'($signed(hil_nxt[i]) * HIL_COEF[i]);
        end
        hil_out = sat_shift(acc);
        comb_a  = word_t'(($signed(stage_a) >>> 1) + ($signed(hil_out) >>> 1));
    end

    // Config is sampled only when a pair is complete so no word mixes settings.
    assign cfg_dec = (take && (ph_r || !dec_r)) ? DECIM_EN_I : dec_r;
    assign cfg_hil = stage_vld ? HILBERT_EN_I : hil_r_en;
    assign cfg_fmt = stage_vld ? TWOS_COMP_I : fmt_r;
    assign cfg_il  = (st_r == OUT_IDLE) ? INTERLEAVE_I : il_r;

    // The pair that closes a boundary already uses the Hilbert and format settings taken at that boundary.
    assign fin.a   = fmt(cfg_hil ? comb_a : stage_a, cfg_fmt);
    assign fin.b   = fmt(stage_b, cfg_fmt);
    assign fin_vld = stage_vld;

    rx_fifo #(.W($bits(pair_s)), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .MCLK_I      (MCLK_I),
        .ARST_N_I    (ARST_N_I),
        .IN_DATA_I   (fin),
        .IN_VALID_I  (fin_vld),
        .IN_READY_O  (fin_rdy),
        .OUT_DATA_O  (fout),
        .OUT_VALID_O (fout_vld),
        .OUT_READY_I (fout_rdy)
    );

    // Output mux: A word then B word on bus A when interleaved.
    // The word leaving the idle state is routed by the same setting that goes out with it.
    assign fout_rdy = link.word_ready && ((st_r == OUT_B) || (!cfg_il && st_r == OUT_IDLE));
    always_comb begin
        st_nxt    = st_r;
        bus_a_nxt = bus_a_r;
        bus_b_nxt = bus_b_r;
        tag_nxt   = tag_r;
        wv_nxt    = 1'b0;
        clk_nxt   = 1'b0;
        case (st_r)
            OUT_IDLE: begin
                if (fout_vld && link.word_ready) begin
                    wv_nxt    = 1'b1;
                    clk_nxt   = 1'b1;
                    bus_a_nxt = fout.a;
                    tag_nxt   = 1'b0;
                    if (cfg_il) begin
                        st_nxt = OUT_B;
                    end else begin
                        bus_b_nxt = fout.b;
                    end
                end
            end
            OUT_B: begin
                if (link.word_ready) begin
                    wv_nxt    = 1'b1;
                    clk_nxt   = 1'b1;
                    bus_a_nxt = fout.b;
                    tag_nxt   = 1'b1;
                    st_nxt    = OUT_IDLE;
                end
            end
            default: st_nxt = OUT_IDLE;
        endcase
    end

    always_comb begin
        pwr_nxt   = pwr_r;
        shref_nxt = shref_r;
        if (REG_WR_I && REG_ADDR_I == REG_PWRDN_IDX) begin
            pwr_nxt = REG_WDATA_I[1:0];
        end else if (REG_WR_I && REG_ADDR_I == REG_SHREF_IDX) begin
            shref_nxt = REG_WDATA_I[SHREF_BIT];
        end
        if (REG_ADDR_I == REG_PWRDN_IDX) begin
            REG_RDATA_O = {6'h00, pwr_r};
        end else if (REG_ADDR_I == REG_SHREF_IDX) begin
            REG_RDATA_O = {6'h00, shref_r, 1'b0};
        end else begin
            REG_RDATA_O = 8'h00;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            for (int i = 0; i < HB_TAPS; i++) begin
                dla_r[i] <= '0;
                dlb_r[i] <= '0;
            end
            for (int i = 0; i < HIL_TAPS; i++) begin
                hil_r[i] <= '0;
            end
            ph_r     <= 1'b0;
            div_r    <= 1'b0;
            dec_r    <= 1'b0;
            hil_r_en <= 1'b0;
            fmt_r    <= 1'b1;
            il_r     <= 1'b0;
            pwr_r    <= PWRDN_RESET;
            shref_r  <= 1'b0;
            st_r     <= OUT_IDLE;
            bus_a_r  <= '0;
            bus_b_r  <= '0;
            tag_r    <= 1'b0;
            wv_r     <= 1'b0;
            clk_r    <= 1'b0;
        end else begin
            dla_r    <= dla_nxt;
            dlb_r    <= dlb_nxt;
            hil_r    <= hil_nxt;
            ph_r     <= cfg_dec != dec_r ? 1'b0 : ph_nxt;
            div_r    <= div_nxt;
            dec_r    <= cfg_dec;
            hil_r_en <= cfg_hil;
            fmt_r    <= cfg_fmt;
            il_r     <= cfg_il;
            pwr_r    <= pwr_nxt;
            shref_r  <= shref_nxt;
            st_r     <= st_nxt;
            bus_a_r  <= bus_a_nxt;
            bus_b_r  <= bus_b_nxt;
            tag_r    <= tag_nxt;
            wv_r     <= wv_nxt;
            clk_r    <= clk_nxt;
        end
    end

    // A full FIFO drops new pairs; the capturer must keep word_ready high on average.
    assign PATH_PWRDN_O                = pwr_r;
    assign SHARED_REF_O                = shref_r;
    assign link.bus_a                  = bus_a_r;
    assign link.bus_b                  = bus_b_r;
    assign link.channel_tag_out        = tag_r;
    assign link.word_valid             = wv_r;
    assign link.interleave             = il_r;
    assign link.primary_output_clock   = clk_r && !CLK_SEL_I;
    assign link.secondary_output_clock = clk_r && CLK_SEL_I;
endmodule : rx_back_end

/* shared/rx_pkg.sv */
// Constants and types shared by both ends of the receive back end link.
// Assumes one clock domain for the device and the capturing end, and
// that the capturing end is fed the device's output clock enables.
// Contract
// - Enabled decimator: 11-tap half-band, one out per two.
// - Decimator bypass passes samples at full rate.
// - Hilbert transform applied to channel B stream.
// - Hilbert mode combines A with shifted B.
// - Hilbert passband 25 to 75 percent, ripple small.
// - Configurer keeps Hilbert input at most 32 MSPS.
// - Output coding twos complement or offset binary.
// - Interleave both channels onto one converter-width bus.
// - Channel tag marks A or B per word.
// - Otherwise drive two parallel converter-width buses.
// - Capturer latches words on selected output clock.
// - Paths enabled at reset, each with power-down bit.
// - Shared reference set by bit one of register four.
// - Channel tag valid when decimated and interleaved.
// - Interleaved words share bus A at double rate.
// - Rate halving samples at clock or half clock.
package rx_pkg;
    localparam int DW = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW = 5;
    localparam int HB_TAPS = 11;
    localparam int HIL_TAPS = 7;
    localparam int COEF_W = 10;
    localparam int COEF_FRAC = 9;
    localparam logic [7:0] REG_PWRDN_IDX = 8'h01;
    localparam logic [7:0] REG_SHREF_IDX = 8'h04;
    localparam int SHREF_BIT = 1;
    localparam logic [1:0] PWRDN_RESET = 2'h0;
    localparam int ACC_W = DW + COEF_W + 4;
    // Half-band coefficients, scaled by 2^COEF_FRAC; odd taps off centre are zero.
    localparam logic signed [COEF_W-1:0] HB_COEF [HB_TAPS] = '{
        10'sh006, 10'sh000, -10'sh020, 10'sh000, 10'sh09A, 10'sh100,
        10'sh09A, 10'sh000, -10'sh020, 10'sh000, 10'sh006};
    // Antisymmetric Hilbert coefficients, passband 25 to 75 percent of Nyquist.
    localparam logic signed [COEF_W-1:0] HIL_COEF [HIL_TAPS] = '{
        -10'sh036, 10'sh000, -10'sh0A3, 10'sh000, 10'sh0A3, 10'sh000, 10'sh036};
    typedef logic [DW-1:0] word_t;
    typedef struct packed {
        word_t a;
        word_t b;
    } pair_s;
    function automatic word_t sat_shift(input logic signed [ACC_W-1:0] acc);
        logic signed [ACC_W-1:0] s;
        s = acc >>> COEF_FRAC;
        if (s > $signed({{(ACC_W-DW+1){1'b0}}, {(DW-1){1'b1}}})) begin
            return {1'b0, {(DW-1){1'b1}}};
        end else if (s < -$signed({{(ACC_W-DW){1'b0}}, 1'b1, {(DW-1){1'b0}}})) begin
            return {1'b1, {(DW-1){1'b0}}};
        end
        return s[DW-1:0];
    endfunction : sat_shift
endpackage : rx_pkg

/* shared/rx_link_if.sv */
// Link between the receive back end and the capturing end.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface rx_link_if;
    import rx_pkg::*;
    logic  primary_output_clock;
    logic  secondary_output_clock;
    word_t bus_a;
    word_t bus_b;
    logic  channel_tag_out;
    logic  word_valid;
    logic  word_ready;
    logic  interleave;
    modport dev (output primary_output_clock, output secondary_output_clock, output bus_a, output bus_b,
                 output channel_tag_out, output word_valid, output interleave, input word_ready);
    modport cap (input primary_output_clock, input secondary_output_clock, input bus_a, input bus_b,
                 input channel_tag_out, input word_valid, input interleave, output word_ready);
endinterface : rx_link_if

/* src/rx_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/1ps
module rx_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input  wire logic         MCLK_I,
    input  wire logic         ARST_N_I,
    input  wire logic [W-1:0] IN_DATA_I,
    input  wire logic         IN_VALID_I,
    output logic              IN_READY_O,
    output logic [W-1:0]      OUT_DATA_O,
    output logic              OUT_VALID_O,
    input  wire logic         OUT_READY_I
);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp_r, wp_nxt, rp_r, rp_nxt;
    logic         push, pop;
    assign IN_READY_O  = (wp_r - rp_r) != (AW+1)'(DEPTH);
    assign OUT_VALID_O = wp_r != rp_r;
    assign OUT_DATA_O  = mem[rp_r[AW-1:0]];
    assign push = IN_VALID_I && IN_READY_O;
    assign pop  = OUT_VALID_O && OUT_READY_I;
    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    end
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end
    // Storage has no reset so it can map to RAM.
    always_ff @(posedge MCLK_I) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= IN_DATA_I;
        end
    end
endmodule : rx_fifo

/* src/rx_capture.sv */
// Capturing end: latches words on the selected output clock marker.
// Assumes the device end runs on the same core clock.
`timescale 1ns/1ps
module rx_capture
    import rx_pkg::*;
(
    input  wire logic          MCLK_I,
    input  wire logic          ARST_N_I,
    input  wire logic          CLK_SEL_I,
    input  wire logic          READY_I,
    output rx_pkg::word_t      CAP_A_O,
    output rx_pkg::word_t      CAP_B_O,
    output logic               CAP_VALID_O,
    rx_link_if.cap             link
);
    import rx_pkg::*;
    logic  edge_seen;
    word_t a_r, a_nxt, b_r, b_nxt;
    logic  v_r, v_nxt;
    assign link.word_ready = READY_I;
    assign edge_seen = CLK_SEL_I ? link.secondary_output_clock : link.primary_output_clock;
    always_comb begin
        a_nxt = a_r;
        b_nxt = b_r;
        v_nxt = 1'b0;
        if (edge_seen) begin
            if (!link.interleave) begin
                a_nxt = link.bus_a;
                b_nxt = link.bus_b;
                v_nxt = 1'b1;
            end else if (!link.channel_tag_out) begin
                a_nxt = link.bus_a;
            end else begin
                b_nxt = link.bus_a;
                v_nxt = 1'b1;
            end
        end
    end
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            a_r <= '0;
            b_r <= '0;
            v_r <= 1'b0;
        end else begin
            a_r <= a_nxt;
            b_r <= b_nxt;
            v_r <= v_nxt;
        end
    end
    assign CAP_A_O     = a_r;
    assign CAP_B_O     = b_r;
    assign CAP_VALID_O = v_r;
endmodule : rx_capture

/* sim/rx_link_props.sv */
// Concurrent checks on the receive link between the back end and the capturing end.
// Assumes one core clock and the link signals handed in as plain inputs.
`timescale 1ns/1ps
module rx_link_props
    import rx_pkg::*;
(
    input  wire logic          MCLK_I,
    input  wire logic          ARST_N_I,
    input  wire logic          primary_output_clock,
    input  wire logic          secondary_output_clock,
    input  wire rx_pkg::word_t bus_a,
    input  wire rx_pkg::word_t bus_b,
    input  wire logic          channel_tag_out,
    input  wire logic          word_valid,
    input  wire logic          word_ready,
    input  wire logic          interleave
);
    logic pend_r;
    logic pend_nxt;

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    // Remembers an A word that still waits for its B partner.
    always_comb begin
        pend_nxt = pend_r;
        if (word_valid && interleave && !channel_tag_out) begin
            pend_nxt = 1'b1;
        end else if (word_valid && channel_tag_out) begin
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    sequence a_word_s;
        word_valid && interleave && !channel_tag_out;
    endsequence

    ab_order_a: assert property (a_word_s |-> ##[1:200] (word_valid && channel_tag_out))
        else $error("Channel B word did not follow channel A word");
    b_after_a_a: assert property (word_valid && channel_tag_out |-> pend_r)
        else $error("Channel B word without a preceding channel A word");
    pair_boundary_a: assert property (pend_r |-> interleave)
        else $error("Interleave setting changed inside a pair");
    tag_mode_a: assert property (word_valid && channel_tag_out |-> interleave)
        else $error("Channel tag set while not interleaving");
    marker_word_a: assert property (word_valid |-> $onehot({primary_output_clock, secondary_output_clock}))
        else $error("Word without exactly one output clock marker");
    word_marker_a: assert property (primary_output_clock || secondary_output_clock |-> word_valid)
        else $error("Output clock marker without a word");
    bus_hold_a: assert property (!word_valid |-> $stable(bus_a) && $stable(bus_b))
        else $error("Data bus moved between words");
    tag_hold_a: assert property (!word_valid |-> $stable(channel_tag_out))
        else $error("Channel tag moved between words");

    cover property (a_word_s);
    cover property (word_valid && !interleave && word_ready);
    cover property (word_valid && secondary_output_clock);
endmodule : rx_link_props

/* sim/test_rx_decimate_hilbert_outmux.sv */
// Self-checking bench joining the receive back end to the capturing end.
// Assumes one 250 MHz core clock shared by both ends and the link interface.
`timescale 1ns/1ps
module test_rx_decimate_hilbert_outmux;
    import rx_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    word_t       adc_a = 12'h000, adc_b = 12'h000, cap_a, cap_b, last_a, last_b;
    logic        stb = 1'b0, decim = 1'b0, hil = 1'b0, twos = 1'b1, ilv = 1'b0, halve = 1'b0;
    logic        clk_sel = 1'b0, reg_wr = 1'b0, ready = 1'b1, shref, take, cap_valid;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
    logic [1:0]  pwrdn;
    logic [12:0] wq[$];
    int          error_cnt = 0, cmp_count = 0, cap_cnt = 0, take_cnt = 0;

    always #2 clk = ~clk;

    rx_link_if i_rx_link_if();
    rx_back_end i_rx_back_end(.MCLK_I(clk), .ARST_N_I(rst_n), .ADC_A_I(adc_a), .ADC_B_I(adc_b), .ADC_STB_I(stb),
        .DECIM_EN_I(decim), .HILBERT_EN_I(hil), .TWOS_COMP_I(twos), .INTERLEAVE_I(ilv),
        .SAMPLE_RATE_HALVE_I(halve), .CLK_SEL_I(clk_sel), .REG_WR_I(reg_wr), .REG_ADDR_I(reg_addr),
        .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata), .PATH_PWRDN_O(pwrdn), .SHARED_REF_O(shref),
        .SAMPLE_TAKE_O(take), .link(i_rx_link_if.dev));
    rx_capture i_rx_capture(.MCLK_I(clk), .ARST_N_I(rst_n), .CLK_SEL_I(clk_sel), .READY_I(ready), .CAP_A_O(cap_a),
        .CAP_B_O(cap_b), .CAP_VALID_O(cap_valid), .link(i_rx_link_if.cap));
    rx_link_props i_rx_link_props(.MCLK_I(clk), .ARST_N_I(rst_n),
        .primary_output_clock(i_rx_link_if.primary_output_clock),
        .secondary_output_clock(i_rx_link_if.secondary_output_clock), .bus_a(i_rx_link_if.bus_a),
        .bus_b(i_rx_link_if.bus_b), .channel_tag_out(i_rx_link_if.channel_tag_out),
        .word_valid(i_rx_link_if.word_valid), .word_ready(i_rx_link_if.word_ready),
        .interleave(i_rx_link_if.interleave));

    always @(posedge clk) begin
        if (cap_valid === 1'b1) begin
            cap_cnt++;
            last_a = cap_a;
            last_b = cap_b;
        end
        if (take === 1'b1) begin
            take_cnt++;
        end
        if (i_rx_link_if.word_valid === 1'b1) begin
            wq.push_back({i_rx_link_if.channel_tag_out, i_rx_link_if.bus_a});
        end
    end

    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        reg_addr <= addr;
        @(posedge clk);
        #1 data = reg_rdata;
    endtask : reg_read

    // Strobes are four cycles apart so an interleaved pair always drains before the next one.
    task automatic send(input word_t a, input word_t b, input int n);
        repeat (n) begin
            @(posedge clk);
            adc_a <= a;
            adc_b <= b;
            stb <= 1'b1;
            @(posedge clk);
            stb <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : send

    // Bits are decimate, Hilbert, twos complement, interleave, halve, clock select.
    task automatic mode(input logic [5:0] m);
        @(posedge clk);
        {decim, hil, twos, ilv, halve, clk_sel} <= m;
        repeat (4) @(posedge clk);
        cap_cnt = 0;
        take_cnt = 0;
        wq.delete();
    endtask : mode

    task automatic settle(input int n);
        for (int i = 0; i < 400 && cap_cnt < n; i++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask : settle

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #50000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(REG_PWRDN_IDX, rd);
        chk_val("pwrdn_reg", 16'h0000, {8'h00, rd});
        chk_val("pwrdn_out", 16'h0000, {14'h0000, pwrdn});
        reg_write(REG_PWRDN_IDX, 8'h02);
        reg_read(REG_PWRDN_IDX, rd);
        chk_val("pwrdn_reg", 16'h0002, {8'h00, rd});
        chk_val("pwrdn_out", 16'h0002, {14'h0000, pwrdn});
        reg_write(REG_SHREF_IDX, 8'h02);
        reg_read(REG_SHREF_IDX, rd);
        chk_val("shref_reg", 16'h0002, {8'h00, rd});
        reg_read(8'h33, rd);
        chk_val("unmapped", 16'h0000, {8'h00, rd});
        chk_val("shared_ref", 16'h0001, {15'h0000, shref});
        reg_write(REG_PWRDN_IDX, 8'h00);
        mode(6'h08);
        send(12'h123, 12'hA5C, 4);
        settle(4);
        chk_val("par_count", 16'h0004, 16'(cap_cnt));
        chk_val("par_a", 16'h0123, {4'h0, last_a});
        chk_val("par_b", 16'h0A5C, {4'h0, last_b});
        mode(6'h00);
        send(12'h123, 12'hA5C, 2);
        settle(2);
        chk_val("ofs_a", 16'h0923, {4'h0, last_a});
        chk_val("ofs_b", 16'h025C, {4'h0, last_b});
        mode(6'h0D);
        send(12'h0F1, 12'h70E, 3);
        settle(3);
        chk_val("ilv_words", 16'h0006, 16'(wq.size()));
        for (int k = 0; k < 6 && k < wq.size(); k++) begin
            chk_val("ilv_word", (k % 2 == 1) ? 16'h170E : 16'h00F1, {3'h0, wq[k]});
        end
        chk_val("cap_a", 16'h00F1, {4'h0, last_a});
        chk_val("cap_b", 16'h070E, {4'h0, last_b});
        mode(6'h2C);
        send(12'h200, 12'hE00, 40);
        settle(20);
        chk_val("dec_count", 16'h0014, 16'(cap_cnt));
        chk_val("dec_a", 16'h0200, {4'h0, last_a});
        chk_val("dec_b", 16'h0E00, {4'h0, last_b});
        if (wq.size() > 1) begin
            chk_val("dec_tag_a", 16'h0200, {3'h0, wq[$-1]});
            chk_val("dec_tag_b", 16'h1E00, {3'h0, wq[$]});
        end
        mode(6'h38);
        send(12'h200, 12'h400, 40);
        settle(20);
        chk_val("hil_a", 16'h0100, {4'h0, last_a});
        mode(6'h0A);
        send(12'h055, 12'h0AA, 20);
        settle(10);
        chk_val("halve_take", 16'h000A, 16'(take_cnt));
        chk_val("halve_count", 16'h000A, 16'(cap_cnt));
        mode(6'h08);
        ready <= 1'b0;
        send(12'h3C3, 12'h1E1, 40);
        ready <= 1'b1;
        settle(40);
        chk_val("fifo_fill", 16'h0020, 16'(cap_cnt));
        chk_val("fifo_a", 16'h03C3, {4'h0, last_a});
        print_verdict();
    end
endmodule : test_rx_decimate_hilbert_outmux
